// >>> core/codec_power_pcm.sv
// Codec power sequencing, master clock watchdog, PCM serial port and APB registers.
`timescale 1ns/1ps
module codec_power_pcm (
    input  logic        SYS_CLK,
    input  logic        RESET,
    input  logic        PSEL,
    input  logic        PENABLE,
    input  logic        PWRITE,
    input  logic [7:0]  PADDR,
    input  logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic        PREADY,
    output logic        PSLVERR,
    input  logic        MCLK,
    input  logic        FRAME_SYNC_IN,
    input  logic        SERIAL_BIT_CLOCK,
    input  logic        SERIAL_DATA_IN,
    output logic        SERIAL_DATA_OUT,
    output logic        SERIAL_DATA_OUT_OE,
    output logic        DIFFERENTIAL_EARPIECE_AMP_EN,
    output logic        SINGLE_ENDED_EARPIECE_AMP_EN,
    output logic        POWERED_UP,
    output logic        LOW_POWER_DOWN
);
    localparam logic [7:0] MCLK_LIMIT = 8'(codec_pkg::MCLK_LOSS_CYC);
    localparam logic [8:0] FRAME_LEN  = 9'(codec_pkg::FRAME_BITS);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]  bclk_sync_ff;
    logic [2:0]  mclk_sync_ff;
    logic [1:0]  fsync_sync_ff;
    logic [1:0]  din_sync_ff;
    logic        bclk_rise;
    logic        bclk_fall;
    logic        frame_start;
    logic [7:0]  mclk_idle_ff;
    logic        mclk_lost;
    logic [7:0]  pwr_ctrl_ff;
    logic [7:0]  tx_gain_ff;
    logic [1:0]  format_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_val;
    logic        access;
    logic        wr_fire;
    logic        frame_err_ff;
    logic        frame_seen_ff;
    logic [8:0]  frame_cnt_ff;
    codec_pkg::pwr_state_t state_ff;
    codec_pkg::pwr_state_t nxt_state;
    logic        pd_req;
    logic        tx_busy_ff;
    logic [14:0] tx_shift_ff;
    logic [3:0]  tx_idx_ff;
    logic [3:0]  word_len_ff;
    logic        dout_ff;
    logic        oe_ff;
    logic        rx_busy_ff;
    logic [14:0] rx_shift_ff;
    logic [3:0]  rx_idx_ff;
    logic [14:0] rx_data_ff;
    logic [14:0] next_word;

    sample_if #(.W(codec_pkg::SAMPLE_W)) tx_q ();

    // ------------------------------------------------------------------
    // Input synchronisers and edge finders
    // ------------------------------------------------------------------

    // Two flops per pin; a third flop of history for the clocks' edges.
    always_ff @(posedge SYS_CLK) begin
        bclk_sync_ff  <= {bclk_sync_ff[1:0], SERIAL_BIT_CLOCK};
        mclk_sync_ff  <= {mclk_sync_ff[1:0], MCLK};
        fsync_sync_ff <= {fsync_sync_ff[0], FRAME_SYNC_IN};
        din_sync_ff   <= {din_sync_ff[0], SERIAL_DATA_IN};
    end

    // Edges are taken from the second and third stages only.
    assign bclk_rise   = bclk_sync_ff[1] & ~bclk_sync_ff[2];
    assign bclk_fall   = ~bclk_sync_ff[1] & bclk_sync_ff[2];
    assign frame_start = bclk_fall & fsync_sync_ff[1]; // R11

    // ------------------------------------------------------------------
    // Master clock watchdog
    // ------------------------------------------------------------------

    // Counts system cycles since the last master clock transition.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mclk_idle_ff <= 8'h00;
        end else if (mclk_sync_ff[1] ^ mclk_sync_ff[2]) begin
            mclk_idle_ff <= 8'h00;
        end else if (mclk_idle_ff != MCLK_LIMIT) begin
            mclk_idle_ff <= mclk_idle_ff + 8'h01;
        end
    end
    assign mclk_lost = (mclk_idle_ff == MCLK_LIMIT); // R07

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------

    // A push to a full FIFO stalls the bus; all else answers at once.
    assign access  = PSEL & PENABLE;
    assign PREADY  = ~(PWRITE && PADDR == codec_pkg::TX_DATA_OFS && !tx_q.wr_ready);
    assign wr_fire = access & PWRITE & PREADY;
    assign PSLVERR = access & ~(PADDR inside {codec_pkg::PWR_CTRL_OFS, codec_pkg::TX_GAIN_OFS,
        codec_pkg::FORMAT_OFS, codec_pkg::STATUS_OFS, codec_pkg::TX_DATA_OFS,
        codec_pkg::RX_DATA_OFS});
    assign PRDATA  = prdata_ff;
    assign tx_q.wr_valid = access & PWRITE & (PADDR == codec_pkg::TX_DATA_OFS);
    assign tx_q.wr_data  = PWDATA[codec_pkg::SAMPLE_W-1:0];

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rd_val = 32'h0;
        unique case (PADDR)
            codec_pkg::PWR_CTRL_OFS: rd_val[7:0]  = pwr_ctrl_ff;
            codec_pkg::TX_GAIN_OFS:  rd_val[7:0]  = tx_gain_ff;
            codec_pkg::FORMAT_OFS:   rd_val[1:0]  = format_ff;
            codec_pkg::STATUS_OFS: begin
                rd_val[codec_pkg::ST_POWERED]    = (state_ff == codec_pkg::PWR_ON);
                rd_val[codec_pkg::ST_MCLK_LOST]  = mclk_lost;
                rd_val[codec_pkg::ST_LOW_PD]     = LOW_POWER_DOWN;
                rd_val[codec_pkg::ST_DRAINING]   = (state_ff == codec_pkg::PWR_DRAIN);
                rd_val[codec_pkg::ST_FIFO_FULL]  = ~tx_q.wr_ready;
                rd_val[codec_pkg::ST_FIFO_EMPTY] = ~tx_q.rd_valid;
                rd_val[codec_pkg::ST_TX_BUSY]    = tx_busy_ff;
                rd_val[codec_pkg::ST_FRAME_ERR]  = frame_err_ff;
            end
            codec_pkg::RX_DATA_OFS:  rd_val[14:0] = rx_data_ff;
            default:                 rd_val       = 32'h0;
        endcase
    end

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            prdata_ff <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_ff <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Writable in every power state, so setup may precede power-up.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            pwr_ctrl_ff <= codec_pkg::PWR_CTRL_RST; // R02
            tx_gain_ff  <= codec_pkg::TX_GAIN_RST;
            format_ff   <= codec_pkg::FORMAT_RST;
        end else if (wr_fire) begin
            if (PADDR == codec_pkg::PWR_CTRL_OFS) pwr_ctrl_ff <= PWDATA[7:0]; // R03
            if (PADDR == codec_pkg::TX_GAIN_OFS) tx_gain_ff <= PWDATA[7:0];
            if (PADDR == codec_pkg::FORMAT_OFS) format_ff <= PWDATA[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    assign pd_req = ~pwr_ctrl_ff[codec_pkg::PWR_ON_BIT]
                  | tx_gain_ff[codec_pkg::DEEP_PD_BIT]   // R09
                  | mclk_lost;

    // A register power-down waits for an active word; clock loss does not.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            codec_pkg::PWR_OFF:   if (!pd_req) nxt_state = codec_pkg::PWR_ON; // R06
            codec_pkg::PWR_ON: begin
                if (mclk_lost) nxt_state = codec_pkg::PWR_OFF; // R07
                else if (pd_req) nxt_state = tx_busy_ff ? codec_pkg::PWR_DRAIN
                                                        : codec_pkg::PWR_OFF; // R05 R08
            end
            codec_pkg::PWR_DRAIN: if (mclk_lost || !tx_busy_ff) nxt_state = codec_pkg::PWR_OFF;
            default:              nxt_state = codec_pkg::PWR_OFF;
        endcase
    end

    // Holds the power state.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) state_ff <= codec_pkg::PWR_OFF;
        else state_ff <= nxt_state;
    end

    // Earpiece driver choice and power indications.
    assign POWERED_UP = (state_ff != codec_pkg::PWR_OFF);
    assign DIFFERENTIAL_EARPIECE_AMP_EN = POWERED_UP & pwr_ctrl_ff[codec_pkg::EAR_DIFF_BIT]; // R04
    assign SINGLE_ENDED_EARPIECE_AMP_EN = POWERED_UP & ~pwr_ctrl_ff[codec_pkg::EAR_DIFF_BIT];
    assign LOW_POWER_DOWN = ~POWERED_UP & tx_gain_ff[codec_pkg::DEEP_PD_BIT]; // R05

    // ------------------------------------------------------------------
    // Frame length check
    // ------------------------------------------------------------------

    // Counts bit clocks between frame starts; a short or long frame sets a sticky flag.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            frame_cnt_ff  <= 9'h000;
            frame_seen_ff <= 1'b0;
            frame_err_ff  <= 1'b0;
        end else begin
            if (frame_start) begin
                frame_cnt_ff  <= 9'h001;
                frame_seen_ff <= 1'b1;
            end else if (bclk_fall && frame_cnt_ff != 9'h1ff) begin
                frame_cnt_ff <= frame_cnt_ff + 9'h001;
            end
            if (frame_start && frame_seen_ff && frame_cnt_ff != FRAME_LEN) begin
                frame_err_ff <= 1'b1; // R15
            end else if (wr_fire && PADDR == codec_pkg::STATUS_OFS
                         && PWDATA[codec_pkg::ST_FRAME_ERR]) begin
                frame_err_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------------

    // Next word left-justified: linear as is, companded in the top byte.
    assign next_word = format_ff[codec_pkg::FMT_LINEAR_BIT]
        ? (tx_q.rd_valid ? tx_q.rd_data[14:0] : 15'h0000)
        : {codec_pkg::compand(tx_q.rd_valid ? tx_q.rd_data[14:0] : 15'h0000,
                              format_ff[codec_pkg::FMT_ALAW_BIT]), 7'h00}; // R10
    assign tx_q.rd_ready = frame_start & (state_ff == codec_pkg::PWR_ON) & ~pd_req;
    assign SERIAL_DATA_OUT    = dout_ff;
    assign SERIAL_DATA_OUT_OE = oe_ff;

    // Loads at frame start, drives on rises, releases after the last fall.
    always_ff @(posedge SYS_CLK) begin
        if (RESET || mclk_lost) begin
            tx_busy_ff <= 1'b0;
            oe_ff      <= 1'b0; // R07
            dout_ff    <= 1'b0;
            tx_idx_ff  <= 4'h0;
        end else if (tx_q.rd_ready) begin
            tx_busy_ff  <= 1'b1;
            tx_idx_ff   <= 4'h0;
            tx_shift_ff <= next_word;
            word_len_ff <= format_ff[codec_pkg::FMT_LINEAR_BIT] ? codec_pkg::LINEAR_BITS
                                                                : codec_pkg::COMPAND_BITS;
        end else if (tx_busy_ff && bclk_rise && tx_idx_ff != word_len_ff) begin
            dout_ff     <= tx_shift_ff[14]; // R13
            oe_ff       <= 1'b1;
            tx_shift_ff <= {tx_shift_ff[13:0], 1'b0};
            tx_idx_ff   <= tx_idx_ff + 4'h1;
        end else if (tx_busy_ff && bclk_fall && tx_idx_ff == word_len_ff) begin
            oe_ff      <= 1'b0; // R14
            tx_busy_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------------

    // Shifts one bit per falling edge after frame start, MSB first.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rx_busy_ff  <= 1'b0;
            rx_idx_ff   <= 4'h0;
            rx_shift_ff <= 15'h0000;
            rx_data_ff  <= 15'h0000;
        end else if (tx_q.rd_ready) begin
            rx_busy_ff <= 1'b1;
            rx_idx_ff  <= 4'h0;
        end else if (rx_busy_ff && bclk_fall) begin
            rx_shift_ff <= {rx_shift_ff[13:0], din_sync_ff[1]}; // R12
            rx_idx_ff   <= rx_idx_ff + 4'h1;
            if (rx_idx_ff + 4'h1 == word_len_ff) begin
                rx_busy_ff <= 1'b0;
                rx_data_ff <= {rx_shift_ff[13:0], din_sync_ff[1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Sample store
    // ------------------------------------------------------------------
    sample_fifo #(.WIDTH(codec_pkg::SAMPLE_W), .DEPTH(codec_pkg::FIFO_DEPTH)) u_fifo (
        .clk (SYS_CLK),
        .rst (RESET),
        .q   (tx_q)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_reset_defaults;
        @(posedge SYS_CLK) $fell(RESET) |-> pwr_ctrl_ff == codec_pkg::PWR_CTRL_RST
            && tx_gain_ff == codec_pkg::TX_GAIN_RST && state_ff == codec_pkg::PWR_OFF;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state"); // R02

    property p_write_off;
        @(posedge SYS_CLK) disable iff (RESET)
        wr_fire && PADDR == codec_pkg::PWR_CTRL_OFS && !POWERED_UP
            |=> pwr_ctrl_ff == $past(PWDATA[7:0]);
    endproperty
    a_write_off: assert property (p_write_off) else $error("write lost while off"); // R03

    property p_earpiece;
        @(posedge SYS_CLK) disable iff (RESET)
        POWERED_UP |-> DIFFERENTIAL_EARPIECE_AMP_EN != SINGLE_ENDED_EARPIECE_AMP_EN
            && DIFFERENTIAL_EARPIECE_AMP_EN == pwr_ctrl_ff[1];
    endproperty
    a_earpiece: assert property (p_earpiece) else $error("wrong earpiece"); // R04

    property p_power_down;
        @(posedge SYS_CLK) disable iff (RESET)
        state_ff == codec_pkg::PWR_ON && pd_req && !tx_busy_ff
            |=> !POWERED_UP && LOW_POWER_DOWN == tx_gain_ff[7];
    endproperty
    a_power_down: assert property (p_power_down) else $error("no power down"); // R05

    property p_power_up;
        @(posedge SYS_CLK) disable iff (RESET)
        !POWERED_UP && pwr_ctrl_ff[0] && !tx_gain_ff[7] && !mclk_lost |=> POWERED_UP;
    endproperty
    a_power_up: assert property (p_power_up) else $error("no power up"); // R06

    property p_mclk_loss;
        @(posedge SYS_CLK) disable iff (RESET)
        mclk_lost |=> !SERIAL_DATA_OUT_OE && !POWERED_UP;
    endproperty
    a_mclk_loss: assert property (p_mclk_loss) else $error("clock loss ignored"); // R07

    property p_drain;
        @(posedge SYS_CLK) disable iff (RESET)
        state_ff == codec_pkg::PWR_ON && pd_req && !mclk_lost && tx_busy_ff
            && !(bclk_fall && tx_idx_ff == word_len_ff)
            |=> state_ff == codec_pkg::PWR_DRAIN && tx_busy_ff;
    endproperty
    a_drain: assert property (p_drain) else $error("word cut short"); // R08

    property p_override;
        @(posedge SYS_CLK) disable iff (RESET)
        tx_gain_ff[7] && !tx_busy_ff ##1 tx_gain_ff[7] |-> !POWERED_UP;
    endproperty
    a_override: assert property (p_override) else $error("override ignored"); // R09

    property p_first_bit;
        @(posedge SYS_CLK) disable iff (RESET || mclk_lost)
        tx_busy_ff && bclk_rise && tx_idx_ff == 4'h0 && !tx_q.rd_ready
            |=> SERIAL_DATA_OUT_OE && SERIAL_DATA_OUT == $past(tx_shift_ff[14]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit wrong"); // R13

    property p_release;
        @(posedge SYS_CLK) disable iff (RESET)
        tx_busy_ff && bclk_fall && tx_idx_ff == word_len_ff && !tx_q.rd_ready
            |=> !SERIAL_DATA_OUT_OE && !tx_busy_ff;
    endproperty
    a_release: assert property (p_release) else $error("output not released"); // R14
endmodule

// >>> core/codec_pkg.sv
// Constants, types and the sample compander shared by the codec power and PCM port logic.
// How it works
// R01 - Host holds reset low at least 500 ns; RESET here is active high.
// R02 - Reset loads every register with its default.
// R03 - Registers are writable while powered down.
// R04 - Power-up bit 1 picks differential or single-ended earpiece.
// R05 - Clearing bit 0 powers down; gain bit 7 deepens.
// R06 - Setting bit 0 powers up with kept settings.
// R07 - Lost master clock forces power-down, output Hi-Z.
// R08 - Power-down waits for the transmit word to finish.
// R09 - Gain bit 7 powers down regardless of clock.
// R10 - Samples go out 15-bit linear or 8-bit companded.
// R11 - Frame starts when sync is high at falling edge.
// R12 - Received bits are captured on falling edges.
// R13 - Transmit bits driven after rising edges, bit 1 first.
// R14 - Output released after the last bit's falling edge.
// R15 - Host gives 256 bit clocks per frame.
package codec_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int RESET_MIN_NS   = 500;
    localparam int RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCLK_LOSS_NS   = 2000;
    localparam int MCLK_LOSS_CYC  = (MCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_BITS     = 256;

    // ------------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------------
    localparam int SAMPLE_W       = 16;
    localparam int FIFO_DEPTH     = 32;
    localparam logic [3:0] LINEAR_BITS  = 4'hf;
    localparam logic [3:0] COMPAND_BITS = 4'h8;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] PWR_CTRL_OFS = 8'h00;
    localparam logic [7:0] TX_GAIN_OFS  = 8'h04;
    localparam logic [7:0] FORMAT_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0c;
    localparam logic [7:0] TX_DATA_OFS  = 8'h10;
    localparam logic [7:0] RX_DATA_OFS  = 8'h14;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] TX_GAIN_RST  = 8'h08;
    localparam logic [1:0] FORMAT_RST   = 2'h1;
    localparam int PWR_ON_BIT     = 0;
    localparam int EAR_DIFF_BIT   = 1;
    localparam int DEEP_PD_BIT    = 7;
    localparam int FMT_LINEAR_BIT = 0;
    localparam int FMT_ALAW_BIT   = 1;
    localparam int ST_POWERED     = 0;
    localparam int ST_MCLK_LOST   = 1;
    localparam int ST_LOW_PD      = 2;
    localparam int ST_DRAINING    = 3;
    localparam int ST_FIFO_FULL   = 4;
    localparam int ST_FIFO_EMPTY  = 5;
    localparam int ST_TX_BUSY     = 6;
    localparam int ST_FRAME_ERR   = 7;

    typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_DRAIN} pwr_state_t;

    // Turns a 15-bit two's-complement sample into a mu-law or A-law byte.
    function automatic logic [7:0] compand(input logic [14:0] s, input logic alaw);
        logic        sgn;
        logic [13:0] mag;
        logic [12:0] m13;
        logic [13:0] b;
        logic [2:0]  seg;
        logic [3:0]  man;
        sgn = s[14];
        mag = sgn ? 14'(~s[13:0] + 14'h1) : s[13:0];
        if (sgn && mag == 14'h0) begin
            mag = 14'h3fff;
        end
        m13 = mag[13:1];
        seg = 3'h0;
        if (alaw) begin
            for (int i = 5; i <= 11; i++) begin
                if (m13[i]) seg = 3'(i - 4);
            end
            man = (seg == 3'h0) ? m13[4:1] : 4'(m13 >> seg);
            return {~sgn, seg, man} ^ 8'h55;
        end
        b = {1'b0, m13} + 14'h0021;
        if (b > 14'h1fff) begin
            b = 14'h1fff;
        end
        for (int i = 6; i <= 12; i++) begin
            if (b[i]) seg = 3'(i - 5);
        end
        man = 4'(b >> ({1'b0, seg} + 4'h1));
        return ~{sgn, seg, man};
    endfunction

endpackage

// >>> core/sample_if.sv
// Valid/ready carrier between the register side and the transmit sample store.
`timescale 1ns/1ps
interface sample_if #(parameter int W = 16);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;

    modport producer (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
    modport store    (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface

// >>> core/sample_fifo.sv
// Flip-flop FIFO holding transmit samples between software and the serial port.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input logic   clk,
    input logic   rst,
    sample_if.store q
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wptr_ff;
    logic [AW:0]      rptr_ff;
    logic             full;
    logic             empty;

    // Extra pointer bit tells full from empty.
    assign full       = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    assign empty      = (wptr_ff == rptr_ff);
    assign q.wr_ready = ~full;
    assign q.rd_valid = ~empty;
    assign q.rd_data  = mem_ff[rptr_ff[AW-1:0]];

    // Stores a word on an accepted push.
    always_ff @(posedge clk) begin
        if (q.wr_valid && !full) begin
            mem_ff[wptr_ff[AW-1:0]] <= q.wr_data;
        end
    end

    // Moves the pointers on accepted pushes and pops.
    always_ff @(posedge clk) begin
        if (rst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            if (q.wr_valid && !full) wptr_ff <= wptr_ff + {{AW{1'b0}}, 1'b1};
            if (q.rd_ready && !empty) rptr_ff <= rptr_ff + {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// >>> test/pcm_host.sv
// Host model driving frame sync, a gated bit clock and receive data into the PCM port.
`timescale 1ns/1ps
module pcm_host (
    output logic             bclk,
    output logic             fsync,
    output logic             sdi,
    input  wire logic        run,
    input  wire logic [14:0] word
);
    // Sends one frame per pass while run is high; the bit clock rests low between frames.
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        sdi = 1'b0;
        forever begin
            wait (run);
            // Keeps every link edge off the system clock edge.
            #10;
            fsync = 1'b1;
            for (int i = 0; i < 256; i++) begin
                #200 bclk = 1'b1;
                fsync = (i == 0);
                sdi = (i >= 1 && i <= 15) ? word[15-i] : ~sdi;
                #200 bclk = 1'b0;
            end
        end
    end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the codec power sequencer and PCM serial port.
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        mclk = 1'b0, mck_on = 1'b1, run = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [14:0] rxw = 15'h0;
    logic        pready, pslverr, serr, fs, bck, sdi, sdo, oe, diff, se, pup, lpd;
    logic [14:0] mq[$];
    logic        txq[$];
    logic [7:0]  ctab[4] = '{8'hd5, 8'haa, 8'hff, 8'h80};
    int          err_count = 0, checks = 0, cyc = 0;

    // Design and the host on its PCM side.
    codec_power_pcm dut (.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MCLK(mclk), .FRAME_SYNC_IN(fs), .SERIAL_BIT_CLOCK(bck),
        .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OUT_OE(oe),
        .DIFFERENTIAL_EARPIECE_AMP_EN(diff), .SINGLE_ENDED_EARPIECE_AMP_EN(se),
        .POWERED_UP(pup), .LOW_POWER_DOWN(lpd));
    pcm_host host (.bclk(bck), .fsync(fs), .sdi(sdi), .run(run), .word(rxw));

    // System clock.
    initial forever #25 clk = ~clk;

    // Master clock toggling and a cycle ceiling that cuts a hang short.
    always @(posedge clk) begin
        mclk <= mck_on ? ~mclk : mclk;
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Takes each sent bit at the falling bit clock edge, while it stands.
    always @(negedge bck) if (oe === 1'b1) txq.push_back(sdo);

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, s, e);
        end
    endtask

    // One bus transfer; it holds the request until ready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic push(input logic [14:0] w);
        apb(1'b1, codec_pkg::TX_DATA_OFS, 32'(w));
        mq.push_back(w);
    endtask

    // Runs one frame, optionally powering down mid-word; checks the sent word, and the received word only when not powering down.
    task automatic frame(input int n, input logic [14:0] e, input logic pd);
        logic [14:0] v;
        v = 15'h0;
        txq.delete();
        rxw <= 15'($urandom);
        run <= 1'b1;
        @(posedge fs);
        run <= 1'b0;
        if (pd) begin
            repeat (40) @(posedge clk);
            apb(1'b1, codec_pkg::PWR_CTRL_OFS, 32'h0);
            chk(32'(pup), 32'h1);
        end
        repeat (2100) @(posedge clk);
        for (int k = 0; k < n; k++) v = {v[13:0], txq[k]};
        chk(32'(v), 32'(e));
        chk(32'(oe), 32'h0);
        if (!pd) begin
            apb(1'b0, codec_pkg::RX_DATA_OFS, 32'h0);
            chk(rdat & ((32'h1 << n) - 32'h1), 32'(rxw >> (15 - n)));
        end
    endtask

    // Main sequence.
    initial begin
        void'($urandom(50537));
        repeat (codec_pkg::RESET_MIN_CYC + 1) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(codec_pkg::PWR_CTRL_OFS, 32'(codec_pkg::PWR_CTRL_RST));
        rd(codec_pkg::TX_GAIN_OFS, 32'(codec_pkg::TX_GAIN_RST));
        rd(codec_pkg::FORMAT_OFS, 32'(codec_pkg::FORMAT_RST));
        rd(8'h18, 32'h0);
        chk(32'(serr), 32'h1);
        apb(1'b1, codec_pkg::FORMAT_OFS, 32'h2);
        chk(32'(pup), 32'h0);
        apb(1'b1, codec_pkg::PWR_CTRL_OFS, 32'h3);
        chk({29'h0, pup, diff, se}, 32'h6);
        apb(1'b1, codec_pkg::PWR_CTRL_OFS, 32'h1);
        chk({29'h0, pup, diff, se}, 32'h5);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) apb(1'b1, codec_pkg::FORMAT_OFS, 32'h0);
            apb(1'b1, codec_pkg::TX_DATA_OFS, i[0] ? 32'h3fff : 32'h0);
            frame(8, 15'(ctab[i]), 1'b0);
        end
        apb(1'b1, codec_pkg::FORMAT_OFS, 32'h1);
        repeat (2) push(15'($urandom));
        repeat (3) frame(15, (mq.size() > 0) ? mq.pop_front() : 15'h0, 1'b0);
        push(15'($urandom));
        frame(15, mq.pop_front(), 1'b1);
        chk({30'h0, pup, lpd}, 32'h0);
        apb(1'b1, codec_pkg::TX_GAIN_OFS, 32'h88);
        chk(32'(lpd), 32'h1);
        apb(1'b1, codec_pkg::PWR_CTRL_OFS, 32'h1);
        chk(32'(pup), 32'h0);
        apb(1'b1, codec_pkg::TX_GAIN_OFS, 32'h08);
        chk(32'(pup), 32'h1);
        mck_on <= 1'b0;
        repeat (60) @(posedge clk);
        chk({30'h0, pup, oe}, 32'h0);
        apb(1'b0, codec_pkg::STATUS_OFS, 32'h0);
        chk(32'(rdat[1]), 32'h1);
        repeat (32) push(15'($urandom));
        apb(1'b0, codec_pkg::STATUS_OFS, 32'h0);
        chk(32'(rdat[7:4]), 32'h1);
        tally_and_finish();
    end
endmodule
